/* File: core/spi_master_slave_port.sv */
/*
 * Byte-wide full-duplex serial port, master or slave, with its registers
 * on an AHB-Lite slave port. Assumes a single clock mclk, synchronous
 * sys_rst, pin buffers outside, and tick pulses on mclk for slow sources.
 */
// What this block does
// - Enable off frees all four serial lines and stops any transfer.
// - Turning the enable on keeps every control register as it was.
// - Slave select rising mid-byte sets incomplete and done flags together.
// - Incomplete flag is set by hardware only in slave mode; software writes to its register never set done.
// - Clock idle polarity 0 rests the clock high, 1 rests it low.
// - Edge select with polarity picks the sampling clock edge.
// - Shift order 1 sends and receives MSB first, 0 LSB first.
// - Select pin enable 0 leaves the select pin unused and floating.
// - Data write during a transfer is dropped and sets the collision flag.
// - Done flag sets itself at byte end; only software clears it.
// - Master write to the data register starts a full-duplex transfer.
// - Slave shifts data out and in on the external master's clock.
// - Port keeps working in idle states while its clock runs.
// - Two spare format bits are plain read-write storage, reset zero.
// - Mode field selects master clock source or slave mode.
`timescale 1ns/1ps
`include "spi_port_regs.svh"

module spi_master_slave_port #(
	parameter int DIV_A = `DIV_A_RATIO,
	parameter int DIV_B = `DIV_B_RATIO,
	parameter int DIV_C = `DIV_C_RATIO
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic sub_edge_tick,
	input wire logic timer_match_tick,
	input wire spi_port_pkg::pins_in_t pins_in,
	output spi_port_pkg::pins_out_t pins_out
);

	// -----------------------------------------------------------------------
	// Parameter check and divider limits
	// -----------------------------------------------------------------------
	if (DIV_A < 2 || DIV_A > 64 || DIV_A % 2 != 0 ||
		DIV_B < 2 || DIV_B > 64 || DIV_B % 2 != 0 ||
		DIV_C < 2 || DIV_C > 64 || DIV_C % 2 != 0) begin : g_chk
		$error("clock ratios must be even and within 2 to 64");
	end

	localparam logic [4:0] HALF_A = 5'(DIV_A / 2 - 1);
	localparam logic [4:0] HALF_B = 5'(DIV_B / 2 - 1);
	localparam logic [4:0] HALF_C = 5'(DIV_C / 2 - 1);

	// -----------------------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------------------
	spi_port_pkg::port_state_t r;
	spi_port_pkg::port_state_t n;
	logic [2:0] sync_q;
	logic sk;
	logic ss;
	logic di;
	logic [2:0] mode;
	logic active;
	logic master;
	logic slave;
	logic idle_lvl;
	logic msb;
	logic cke;
	logic select_pin_enable;
	logic busy;
	logic [4:0] half_lim;
	logic div_tick;
	logic tick;
	logic sel_ok;
	logic slave_edge;
	logic ev;
	logic sample;
	logic cap;
	logic abort;
	logic rd_phase;
	logic [31:0] rd_word;

	// -----------------------------------------------------------------------
	// Pin synchroniser
	// -----------------------------------------------------------------------
	pin_sync3 #(
		.W(3),
		.INIT(3'h2)
	) u_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pin_async({pins_in.serial_in, pins_in.scs_n, pins_in.sck}),
		.pin_stable(sync_q)
	);

	assign sk = sync_q[0];
	assign ss = sync_q[1];
	assign di = sync_q[2];

	// -----------------------------------------------------------------------
	// Configuration decode
	// -----------------------------------------------------------------------
	assign mode = r.mec[`MEC_MODE_LSB +: 3];
	assign active = r.mec[`MEC_EN_BIT] && !r.mec[`MEC_UMD_BIT] &&
		(mode <= `MODE_SLAVE);
	assign master = active && (mode != `MODE_SLAVE);
	assign slave = active && (mode == `MODE_SLAVE);
	assign idle_lvl = ~r.sfc[`SFC_CPOL_BIT];
	assign msb = r.sfc[`SFC_MLS_BIT];
	assign cke = r.sfc[`SFC_CLOCK_EDGE_SELECT_BIT];
	assign select_pin_enable = r.sfc[`SFC_SELECT_PIN_ENABLE_BIT];
	assign busy = (r.st != spi_port_pkg::ST_IDLE);

	// -----------------------------------------------------------------------
	// Master clock source
	// -----------------------------------------------------------------------
	assign half_lim = (mode == `MODE_DIV16) ? HALF_B :
		(mode == `MODE_DIV64) ? HALF_C : HALF_A;
	assign div_tick = (r.div_cnt == half_lim);
	assign tick = (mode == `MODE_SUB) ? sub_edge_tick :
		(mode == `MODE_TMR) ? timer_match_tick : div_tick;

	// -----------------------------------------------------------------------
	// Edge events
	// -----------------------------------------------------------------------
	assign sel_ok = !select_pin_enable || !ss;
	assign slave_edge = (sk != r.sck_prev) &&
		((r.st == spi_port_pkg::ST_RUN) || (sk != idle_lvl));
	assign ev = master ? (r.st == spi_port_pkg::ST_RUN) && tick :
		slave && slave_edge && sel_ok;
	assign sample = cke ? ~r.edge_cnt[0] : r.edge_cnt[0];
	assign cap = slave ? (ev && sample) : r.samp_pipe[2];
	assign abort = slave && select_pin_enable && ss && !r.scs_prev &&
		(r.st == spi_port_pkg::ST_RUN);

	// -----------------------------------------------------------------------
	// Register read mux
	// -----------------------------------------------------------------------
	assign rd_phase = r.ph_valid && !r.ph_write;

	always_comb begin
		if (r.ph_addr == `MEC_OFFSET) begin
			rd_word = {24'h000000, r.mec};
		end else if (r.ph_addr == `SFC_OFFSET) begin
			rd_word = {24'h000000, r.sfc};
		end else if (r.ph_addr == `SDR_OFFSET) begin
			rd_word = {24'h000000, r.sdr};
		end else begin
			rd_word = 32'h00000000;
		end
	end

	// -----------------------------------------------------------------------
	// End of byte
	// -----------------------------------------------------------------------
	function automatic spi_port_pkg::port_state_t finish_xfer(
		input spi_port_pkg::port_state_t s
	);
		spi_port_pkg::port_state_t t;
		t = s;
		t.st = spi_port_pkg::ST_IDLE;
		t.edge_cnt = 4'h0;
		t.samp_pipe = 3'h0;
		t.sdr = s.rx;
		t.tx = s.rx;
		t.sfc[`SFC_TRF_BIT] = 1'b1;
		return t;
	endfunction

	// -----------------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------------
	always_comb begin
		n = r;
		n.sck_prev = sk;
		n.scs_prev = ss;

		// Bus data phase: writes
		if (r.ph_valid && r.ph_write) begin
			if (r.ph_addr == `MEC_OFFSET) begin
				n.mec = hwdata[7:0];
			end else if (r.ph_addr == `SFC_OFFSET) begin
				n.sfc = hwdata[7:0];
			end else if (r.ph_addr == `SDR_OFFSET) begin
				if (busy) begin
					n.sfc[`SFC_WRITE_COLLISION_FLAG_BIT] = 1'b1;
				end else begin
					n.sdr = hwdata[7:0];
					n.tx = hwdata[7:0];
					if (master) begin
						n.st = spi_port_pkg::ST_RUN;
						n.edge_cnt = 4'h0;
						n.div_cnt = 5'h00;
						n.samp_pipe = 3'h0;
					end
				end
			end
		end

		// Bus data phase: reads take one wait state
		if (rd_phase && !r.rd_wait) begin
			n.rdata = rd_word;
			n.rd_wait = 1'b1;
		end

		// Bus address phase
		if (hready) begin
			n.ph_valid = hsel && htrans[1];
			n.ph_write = hwrite;
			n.ph_addr = haddr;
			n.rd_wait = 1'b0;
		end

		// Master divider
		if (master && (r.st == spi_port_pkg::ST_RUN)) begin
			n.div_cnt = div_tick ? 5'h00 : r.div_cnt + 5'h01;
		end else begin
			n.div_cnt = 5'h00;
		end

		// Delayed capture lines master sampling up with the pin delay
		n.samp_pipe = {r.samp_pipe[1:0], master && ev && sample};
		if (cap) begin
			n.rx = msb ? {r.rx[6:0], di} : {di, r.rx[7:1]};
		end

		// Transfer sequencing
		if (!active) begin
			n.st = spi_port_pkg::ST_IDLE;
			n.edge_cnt = 4'h0;
			n.samp_pipe = 3'h0;
		end else if (abort) begin
			n.st = spi_port_pkg::ST_IDLE;
			n.edge_cnt = 4'h0;
			n.tx = r.sdr;
			n.sfc[`SFC_TRF_BIT] = 1'b1;
			n.mec[`MEC_ICF_BIT] = 1'b1;
		end else if (ev) begin
			if (master) begin
				n.sck = ~r.sck;
			end
			if (!sample && (r.edge_cnt != 4'h0)) begin
				n.tx = msb ? {r.tx[6:0], 1'b0} : {1'b0, r.tx[7:1]};
			end
			if (r.edge_cnt == `LAST_EDGE) begin
				if (slave) begin
					n = finish_xfer(n);
				end else begin
					n.st = spi_port_pkg::ST_DRAIN;
				end
			end else begin
				n.edge_cnt = r.edge_cnt + 4'h1;
				n.st = spi_port_pkg::ST_RUN;
			end
		end else if ((r.st == spi_port_pkg::ST_DRAIN) && (r.samp_pipe == 3'h0)) begin
			n = finish_xfer(n);
		end

		// Master clock rests at its idle level between bytes
		if (!master || (n.st == spi_port_pkg::ST_IDLE)) begin
			n.sck = idle_lvl;
		end

		n.serial_out = msb ? n.tx[7] : n.tx[0];
	end

	// -----------------------------------------------------------------------
	// State register
	// -----------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			r <= '{
				mec: `MEC_RESET,
				sfc: `SFC_RESET,
				sdr: `SDR_RESET,
				tx: 8'h00,
				rx: 8'h00,
				edge_cnt: 4'h0,
				div_cnt: 5'h00,
				samp_pipe: 3'h0,
				sck: 1'b1,
				serial_out: 1'b0,
				sck_prev: 1'b0,
				scs_prev: 1'b1,
				ph_valid: 1'b0,
				ph_write: 1'b0,
				rd_wait: 1'b0,
				ph_addr: 12'h000,
				rdata: 32'h00000000,
				st: spi_port_pkg::ST_IDLE
			};
		end else begin
			r <= n;
		end
	end

	// -----------------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------------
	assign hrdata = r.rdata;
	assign hreadyout = !(rd_phase && !r.rd_wait);
	assign hresp = 1'b0;

	assign pins_out.sck_out = r.sck;
	assign pins_out.sck_oe = master;
	assign pins_out.sdo_out = r.serial_out;
	assign pins_out.sdo_oe = master || (slave && sel_ok);
	assign pins_out.scs_n_out = !(master && busy);
	assign pins_out.scs_n_oe = master && select_pin_enable;

endmodule

/* File: core/spi_port_regs.svh */
/*
 * Register offsets, field positions, reset values and clock ratios of the
 * serial port. Assumes inclusion by bare name from files under core/.
 */
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH

// ---------------------------------------------------------------------------
// Byte offsets on the register bus
// ---------------------------------------------------------------------------
`define MEC_OFFSET 12'h000
`define SFC_OFFSET 12'h004
`define SDR_OFFSET 12'h008

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define MEC_RESET 8'hE0
`define SFC_RESET 8'h00
`define SDR_RESET 8'h00

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define MEC_MODE_LSB 5
`define MEC_UMD_BIT 4
`define MEC_EN_BIT 1
`define MEC_ICF_BIT 0
`define SFC_CPOL_BIT 5
`define SFC_CLOCK_EDGE_SELECT_BIT 4
`define SFC_MLS_BIT 3
`define SFC_SELECT_PIN_ENABLE_BIT 2
`define SFC_WRITE_COLLISION_FLAG_BIT 1
`define SFC_TRF_BIT 0

// ---------------------------------------------------------------------------
// Mode codes and timing counts
// ---------------------------------------------------------------------------
`define MODE_DIV4 3'h0
`define MODE_DIV16 3'h1
`define MODE_DIV64 3'h2
`define MODE_SUB 3'h3
`define MODE_TMR 3'h4
`define MODE_SLAVE 3'h5
`define DIV_A_RATIO 4
`define DIV_B_RATIO 16
`define DIV_C_RATIO 64
`define LAST_EDGE 4'hF

`endif

/* File: core/spi_port_pkg.sv */
/*
 * Types shared by the serial port files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package spi_port_pkg;

	// -----------------------------------------------------------------------
	// Transfer states
	// -----------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN = 3'b010,
		ST_DRAIN = 3'b100
	} xfer_st_t;

	// -----------------------------------------------------------------------
	// Pin groups
	// -----------------------------------------------------------------------
	typedef struct packed {
		logic sck;
		logic scs_n;
		logic serial_in;
	} pins_in_t;

	typedef struct packed {
		logic sck_out;
		logic sck_oe;
		logic scs_n_out;
		logic scs_n_oe;
		logic sdo_out;
		logic sdo_oe;
	} pins_out_t;

	// -----------------------------------------------------------------------
	// Whole state of the port
	// -----------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] mec;
		logic [7:0] sfc;
		logic [7:0] sdr;
		logic [7:0] tx;
		logic [7:0] rx;
		logic [3:0] edge_cnt;
		logic [4:0] div_cnt;
		logic [2:0] samp_pipe;
		logic sck;
		logic serial_out;
		logic sck_prev;
		logic scs_prev;
		logic ph_valid;
		logic ph_write;
		logic rd_wait;
		logic [11:0] ph_addr;
		logic [31:0] rdata;
		xfer_st_t st;
	} port_state_t;

endpackage

/* File: core/pin_sync3.sv */
/*
 * Three-stage synchroniser for pin inputs; an output bit changes once the
 * second and third stages agree. Assumes mclk and synchronous sys_rst.
 */
`timescale 1ns/1ps

module pin_sync3 #(
	parameter int W = 3,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [W-1:0] pin_async,
	output logic [W-1:0] pin_stable
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_t;

	sync_t r;
	sync_t n;
	logic [W-1:0] agree;

	if (W < 1) begin : g_chk
		$error("pin_sync3 needs at least one bit");
	end

	// -----------------------------------------------------------------------
	// Stages
	// -----------------------------------------------------------------------
	assign agree = ~(r.s2 ^ r.s3);

	always_comb begin
		n = r;
		n.s1 = pin_async;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.q = (r.q & ~agree) | (r.s3 & agree);
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			r <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
		end else begin
			r <= n;
		end
	end

	assign pin_stable = r.q;

endmodule

/* File: sim/spi_port_asserts.sv */
/*
 * Checker of bus timing and serial pin behaviour of the port.
 * Assumes binding to the port top module, one clock mclk.
 */
`timescale 1ns/1ps

module spi_port_asserts (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire spi_port_pkg::pins_out_t pins_out
);
	// ----
	// Register shadows and edge count
	// ----
	logic ph_w;
	logic [11:0] ph_a;
	logic [7:0] mec;
	logic [7:0] sfc;
	logic [4:0] n_edge;
	wire logic master = mec[1] && !mec[4] && mec[7:5] < 3'h5;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ph_w <= 1'b0;
			mec <= 8'hE0;
			sfc <= 8'h00;
		end else if (hready) begin
			ph_w <= hsel && htrans[1] && hwrite;
			ph_a <= haddr;
			if (ph_w && ph_a == 12'h000) mec <= hwdata[7:0];
			if (ph_w && ph_a == 12'h004) sfc <= hwdata[7:0];
		end
	end
	always_ff @(posedge mclk) begin
		if (sys_rst || pins_out.scs_n_out) n_edge <= 5'h00;
		else if (pins_out.sck_out != $past(pins_out.sck_out)) n_edge <= n_edge + 5'h01;
	end
	// ----
	// Properties
	// ----
	a_read_one_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_no_wait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
		else $error("write stalled");
	a_read_high_zero: assert property ($rose(hreadyout) |-> hrdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_off_frees_pins: assert property (!mec[1] |-> !(pins_out.sck_oe || pins_out.sdo_oe || pins_out.scs_n_oe))
		else $error("pin driven while off");
	a_select_floats: assert property (!sfc[2] |-> !pins_out.scs_n_oe)
		else $error("select driven while unused");
	a_mode_drives_clock: assert property (pins_out.sck_oe == master)
		else $error("clock drive disagrees with mode");
	a_clock_rests: assert property (master && $past(master, 2) && $stable(sfc[5]) && sfc[5] == $past(sfc[5], 2)
		&& pins_out.scs_n_out && $past(pins_out.scs_n_out) |-> pins_out.sck_out == !sfc[5])
		else $error("idle clock level wrong");
	a_start_selects: assert property (ph_w && hready && ph_a == 12'h008 && master && pins_out.scs_n_out
		|-> ##[1:2] !pins_out.scs_n_out)
		else $error("transfer did not start");
	a_sixteen_edges: assert property (master && $rose(pins_out.scs_n_out) |-> n_edge == 5'h10)
		else $error("clock edge count wrong");
endmodule

bind spi_master_slave_port spi_port_asserts spi_port_asserts_inst (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hwdata, .hrdata, .hreadyout, .pins_out);

/* File: sim/spi_peer_model.sv */
/*
 * Far-side serial party: peripheral when the port is master, master when it is slave.
 * Assumes the port's mclk and pins behind its synchroniser.
 */
`timescale 1ns/1ps

module spi_peer_model (
	input wire logic mclk,
	input wire logic pol,
	input wire logic edg,
	input wire logic msb,
	input wire logic [7:0] tx,
	input wire logic sck_dut,
	input wire logic sdo_dut,
	output spi_port_pkg::pins_in_t pins,
	output logic [7:0] rx
);
	logic gen = 1'b0;
	logic act = 1'b0;
	int k = 0;
	wire logic clk_seen = gen ? pins.sck : sck_dut;
	initial pins = 3'b110;
	// Sample on the chosen edge, present data on the other
	always @(clk_seen) begin
		if (act && clk_seen == (pol == edg)) begin
			rx[msb ? 7 - k : k] = sdo_dut;
			k++;
			act = k < 8;
		end else if (act) begin
			pins.serial_in = tx[msb ? 7 - k : k];
		end
	end
	// Released data line changes every cycle
	always @(negedge mclk) begin
		if (!act) begin
			pins.serial_in <= ~pins.serial_in;
		end
	end
	task automatic arm();
		k = 0;
		act = 1'b1;
		pins.serial_in = tx[msb ? 7 : 0];
	endtask
	// Select first, then n clock edges, then release
	task automatic master_byte(input int n);
		gen = 1'b1;
		pins.sck = ~pol;
		repeat (8) @(posedge mclk);
		arm();
		pins.scs_n = 1'b0;
		repeat (8) @(posedge mclk);
		repeat (n) begin
			pins.sck = ~pins.sck;
			repeat (8) @(posedge mclk);
		end
		pins.scs_n = 1'b1;
		act = 1'b0;
		repeat (8) @(posedge mclk);
		gen = 1'b0;
	endtask
endmodule

/* File: sim/test_spi_master_slave_port.sv */
/*
 * Self-checking bench of the serial port: registers, master and slave transfers.
 * Assumes the design files under core/ and the peer model.
 */
`timescale 1ns/1ps

module test_spi_master_slave_port;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic sub_edge_tick = 1'b0;
	logic timer_match_tick = 1'b0;
	spi_port_pkg::pins_in_t pins_in;
	spi_port_pkg::pins_out_t pins_out;
	logic pol = 1'b0;
	logic edg = 1'b0;
	logic msb = 1'b0;
	logic [7:0] tx = 8'h00;
	logic [7:0] rx;
	int seed = 41;
	int cyc = 0;
	int error_cnt = 0;
	int n_compared = 0;
	spi_master_slave_port #(.DIV_A(16), .DIV_B(16), .DIV_C(32)) spi_master_slave_port_inst (.mclk, .sys_rst, .hsel,
		.haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp(),
		.sub_edge_tick, .timer_match_tick, .pins_in, .pins_out);
	spi_peer_model spi_peer_model_inst (.mclk, .pol, .edg, .msb, .tx, .sck_dut(pins_out.sck_out),
		.sdo_dut(pins_out.sdo_out), .pins(pins_in), .rx);
	always #2 mclk = ~mclk;
	// ----
	// Slow clock sources and timeout
	// ----
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		sub_edge_tick <= cyc % 8 == 0;
		timer_match_tick <= cyc % 8 == 4;
		if (cyc == 30000) begin
			error_cnt++;
			conclude();
		end
	end
	function automatic logic [7:0] fmt(input logic p, input logic e, input logic m);
		return {2'h0, p, e, m, 3'h4};
	endfunction
	task automatic conclude();
		$display("compared %0d, mismatched %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] r);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(negedge mclk); while (hreadyout !== 1'b1);
		@(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		do @(negedge mclk); while (hreadyout !== 1'b1);
		r = hrdata[7:0];
		@(posedge mclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic chk(input logic [11:0] a, input logic [7:0] exp);
		logic [7:0] r;
		bus(1'b0, a, 8'h00, r);
		cmp(r, exp);
	endtask
	task automatic wait_done();
		logic [7:0] r;
		r = 8'h00;
		for (int t = 0; t < 300 && r[0] !== 1'b1; t++) bus(1'b0, 12'h004, 8'h00, r);
		if (r[0] !== 1'b1) begin
			error_cnt++;
			$display("unexpected at %0t: done flag %h expected %h", $time, r[0], 1'b1);
		end
	endtask
	initial begin
		logic [7:0] d;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		chk(12'h000, 8'hE0);
		chk(12'h004, 8'h00);
		wr(12'h004, 8'hC0);
		chk(12'h004, 8'hC0);
		wr(12'h00C, 8'h5A);
		chk(12'h00C, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			{msb, edg, pol} = i[2:0];
			tx = 8'($random(seed));
			d = 8'($random(seed));
			wr(12'h004, fmt(pol, edg, msb));
			wr(12'h000, {3'(i % 5), 5'h02});
			spi_peer_model_inst.arm();
			wr(12'h008, d);
			wr(12'h008, ~d);
			wait_done();
			chk(12'h004, fmt(pol, edg, msb) | 8'h03);
			chk(12'h008, tx);
			cmp(rx, d);
		end
		wr(12'h000, 8'h00);
		wr(12'h000, 8'h02);
		chk(12'h004, fmt(pol, edg, msb) | 8'h03);
		$display("test master done");
		for (int i = 0; i < 4; i++) begin
			{edg, pol} = i[1:0];
			msb = ~i[0];
			tx = 8'($random(seed));
			d = 8'($random(seed));
			wr(12'h004, fmt(pol, edg, msb));
			wr(12'h000, 8'hA2);
			wr(12'h008, d);
			spi_peer_model_inst.master_byte(16);
			wait_done();
			chk(12'h004, fmt(pol, edg, msb) | 8'h01);
			chk(12'h008, tx);
			cmp(rx, d);
		end
		wr(12'h004, fmt(pol, edg, msb));
		wr(12'h008, d);
		spi_peer_model_inst.master_byte(7);
		chk(12'h004, fmt(pol, edg, msb) | 8'h01);
		chk(12'h000, 8'hA3);
		wr(12'h000, 8'hA2);
		wr(12'h004, fmt(pol, edg, msb));
		wr(12'h000, 8'hA3);
		chk(12'h004, fmt(pol, edg, msb));
		$display("test slave done");
		conclude();
	end
endmodule
